// >>> ifepc_pkg.sv
// Package of constants and carrier types for the interrupt flag, enable and priority controller.
`default_nettype none
package ifepc_pkg;
	// -----------------------------------------------------------------
	// Sizes
	// -----------------------------------------------------------------
	localparam int NUM_SRC       = 64;
	localparam int NUM_FLAG_REGS = 4;
	localparam int NUM_PRIO_REGS = 16;
	localparam int PRIO_PER_REG  = 4;
	localparam logic [6:0] VECTOR_BASE = 7'h08;

	// -----------------------------------------------------------------
	// Register byte offsets
	// -----------------------------------------------------------------
	localparam logic [11:0] OFS_GCA      = 12'h000;
	localparam logic [11:0] OFS_GCB      = 12'h004;
	localparam logic [11:0] OFS_CPU_STAT = 12'h008;
	localparam logic [11:0] OFS_CORE_CTL = 12'h00c;
	localparam logic [11:0] OFS_PVS      = 12'h010;
	localparam logic [11:0] OFS_EVT_STAT = 12'h014;
	localparam logic [11:0] OFS_EVT_MASK = 12'h018;
	localparam logic [11:0] OFS_FLAG0    = 12'h020;
	localparam logic [11:0] OFS_EN0      = 12'h030;
	localparam logic [11:0] OFS_PRIO0    = 12'h040;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int GCA_NEST_DIS_BIT = 15;
	localparam int GCB_ALT_VEC_BIT  = 15;
	localparam int CPU_PRIO_LSB     = 5;
	localparam int CORE_TOP_BIT     = 3;
	localparam int PVS_LEVEL_LSB    = 8;
	localparam int EVT_VEC_BIT      = 0;
	localparam int EVT_TRAP_BIT     = 1;
	localparam int NUM_EVT          = 2;

	// -----------------------------------------------------------------
	// Implemented flag positions and reset values
	// -----------------------------------------------------------------
	localparam logic [15:0] FLAG_IMPL_REG3 = 16'he600;
	localparam logic [NUM_SRC-1:0] FLAG_IMPL = {FLAG_IMPL_REG3, 48'hffff_ffff_ffff};
	localparam logic [2:0] PRIO_RST    = 3'h4;
	localparam logic [2:0] CPU_PRIO_RST = 3'h0;
	localparam logic [2:0] NEST_LEVEL  = 3'h7;

	// -----------------------------------------------------------------
	// Carrier towards the processor core
	// -----------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic [6:0] vector;
		logic [3:0] level;
	} ifepc_req_s;
endpackage
`default_nettype wire

// >>> ifepc_ctrl.sv
// Interrupt flag, enable and priority controller with APB register access.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module ifepc_ctrl #(
	parameter int NUM_EXT  = 1,
	parameter int NUM_TRAP = 5
) (
	// Clock and reset.
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave.
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic                             pready,
	output logic      [31:0]                 prdata,
	output logic                             pslverr,
	// Interrupt sources.
	input  wire logic [ifepc_pkg::NUM_SRC-1:0] src_event,
	input  wire logic [NUM_EXT-1:0]          ext_irq_pin,
	input  wire logic [NUM_TRAP-1:0]         trap_event,
	// Processor core side.
	input  wire logic                        trap_level,
	input  wire logic                        irq_ack,
	output ifepc_pkg::ifepc_req_s            irq_req,
	output logic                             alternate_vector_table,
	output logic                             irq_out
);
	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	logic [ifepc_pkg::NUM_SRC-1:0]      irq_flag_regs_ff;
	logic [ifepc_pkg::NUM_SRC-1:0]      irq_enable_regs_ff;
	logic [ifepc_pkg::NUM_SRC-1:0][2:0] irq_priority_regs_ff;
	logic                               nesting_disable_ff;
	logic [NUM_TRAP-1:0]                trap_flag_ff;
	logic [NUM_EXT-1:0]                 ext_edge_neg_ff;
	logic                               alt_vec_ff;
	logic [2:0]                         cpu_priority_bits_ff;
	logic                               cpu_priority_top_bit_ff;
	ifepc_pkg::ifepc_req_s              pvs_ff;
	logic [ifepc_pkg::NUM_EVT-1:0]      evt_stat_ff;
	logic [ifepc_pkg::NUM_EVT-1:0]      evt_mask_ff;
	logic [NUM_EXT-1:0]                 sync1_ff;
	logic [NUM_EXT-1:0]                 sync2_ff;
	logic [NUM_EXT-1:0]                 sync3_ff;
	logic [NUM_EXT-1:0]                 ext_lvl_ff;
	logic [31:0]                        prdata_ff;
	logic                               pslverr_ff;

	logic [ifepc_pkg::NUM_SRC-1:0]      hw_set;
	logic [NUM_EXT-1:0]                 ext_edge;
	logic [3:0]                         cur_level;
	logic                               best_valid;
	logic [6:0]                         best_idx;
	logic [2:0]                         best_prio;
	logic                               wr_en;
	logic                               setup;
	logic [31:0]                        rd_val;
	logic                               rd_hit;
	logic [11:0]                        ofs_rel;
	logic [1:0]                         grp_sel;
	logic [3:0]                         prio_sel;

	// -----------------------------------------------------------------
	// External pins
	// -----------------------------------------------------------------
	// Three-stage synchroniser; a level counts once stages two and three agree.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end else begin
			sync1_ff <= ext_irq_pin;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// Filtered level of each external pin.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_lvl_ff <= '0;
		end else begin
			for (int i = 0; i < NUM_EXT; i++) begin
				if (sync2_ff[i] == sync3_ff[i]) begin
					ext_lvl_ff[i] <= sync3_ff[i];
				end
			end
		end
	end

	// Edge polarity per pin is chosen by the second control register.
	always_comb begin
		for (int i = 0; i < NUM_EXT; i++) begin
			if (sync2_ff[i] == sync3_ff[i] && sync3_ff[i] != ext_lvl_ff[i]) begin
				ext_edge[i] = ext_edge_neg_ff[i] ? ~sync3_ff[i] : sync3_ff[i];
			end else begin
				ext_edge[i] = 1'b0;
			end
		end
	end

	// External line n drives source n, so line zero lands on flag bit 0.
	always_comb begin
		hw_set = src_event;
		hw_set[NUM_EXT-1:0] = src_event[NUM_EXT-1:0] | ext_edge;
		hw_set = hw_set & ifepc_pkg::FLAG_IMPL;
	end

	// -----------------------------------------------------------------
	// APB decode
	// -----------------------------------------------------------------
	// Writes take effect in the access phase; pready is always high.
	assign wr_en    = psel & penable & pwrite;
	assign setup    = psel & ~penable;
	assign ofs_rel  = paddr - ifepc_pkg::OFS_FLAG0;
	assign grp_sel  = ofs_rel[3:2];
	assign prio_sel = 4'((paddr - ifepc_pkg::OFS_PRIO0) >> 2);

	// -----------------------------------------------------------------
	// Flags, enables and priorities
	// -----------------------------------------------------------------
	// Flags: a hardware set in the cycle of a software write still wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_flag_regs_ff <= '0;
		end else begin
			for (int r = 0; r < ifepc_pkg::NUM_FLAG_REGS; r++) begin
				if (wr_en && paddr == ifepc_pkg::OFS_FLAG0 + 12'(4 * r)) begin
					irq_flag_regs_ff[r*16 +: 16] <= (pwdata[15:0] | hw_set[r*16 +: 16])
						& ifepc_pkg::FLAG_IMPL[r*16 +: 16];
				end else begin
					irq_flag_regs_ff[r*16 +: 16] <= irq_flag_regs_ff[r*16 +: 16]
						| hw_set[r*16 +: 16];
				end
			end
		end
	end

	// Enable bits, one per source.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_regs_ff <= '0;
		end else begin
			for (int r = 0; r < ifepc_pkg::NUM_FLAG_REGS; r++) begin
				if (wr_en && paddr == ifepc_pkg::OFS_EN0 + 12'(4 * r)) begin
					irq_enable_regs_ff[r*16 +: 16] <= pwdata[15:0];
				end
			end
		end
	end

	// Priority fields, four sources per register, three bits in each nibble.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_priority_regs_ff <= {ifepc_pkg::NUM_SRC{ifepc_pkg::PRIO_RST}};
		end else begin
			for (int r = 0; r < ifepc_pkg::NUM_PRIO_REGS; r++) begin
				if (wr_en && paddr == ifepc_pkg::OFS_PRIO0 + 12'(4 * r)) begin
					for (int k = 0; k < ifepc_pkg::PRIO_PER_REG; k++) begin
						irq_priority_regs_ff[r*4 + k] <= pwdata[k*4 +: 3];
					end
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// Global control and CPU level
	// -----------------------------------------------------------------
	// First control register: nesting disable and sticky trap flags.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nesting_disable_ff <= 1'b0;
			trap_flag_ff       <= '0;
		end else begin
			if (wr_en && paddr == ifepc_pkg::OFS_GCA) begin
				nesting_disable_ff <= pwdata[ifepc_pkg::GCA_NEST_DIS_BIT];
				trap_flag_ff       <= pwdata[NUM_TRAP-1:0] | trap_event;
			end else begin
				trap_flag_ff <= trap_flag_ff | trap_event;
			end
		end
	end

	// Second control register: edge polarity and alternate table select.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_edge_neg_ff <= '0;
			alt_vec_ff      <= 1'b0;
		end else if (wr_en && paddr == ifepc_pkg::OFS_GCB) begin
			ext_edge_neg_ff <= pwdata[NUM_EXT-1:0];
			alt_vec_ff      <= pwdata[ifepc_pkg::GCB_ALT_VEC_BIT];
		end
	end

	// CPU level bits: software writes them; an acknowledge raises them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_priority_bits_ff <= ifepc_pkg::CPU_PRIO_RST;
		end else if (irq_ack && pvs_ff.valid) begin
			cpu_priority_bits_ff <= nesting_disable_ff ? ifepc_pkg::NEST_LEVEL
				: pvs_ff.level[2:0];
		end else if (wr_en && paddr == ifepc_pkg::OFS_CPU_STAT) begin
			cpu_priority_bits_ff <= pwdata[ifepc_pkg::CPU_PRIO_LSB +: 3];
		end
	end

	// The top level bit follows the core's trap state and ignores writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_priority_top_bit_ff <= 1'b0;
		end else begin
			cpu_priority_top_bit_ff <= trap_level;
		end
	end

	assign cur_level = {cpu_priority_top_bit_ff, cpu_priority_bits_ff};

	// -----------------------------------------------------------------
	// Arbitration
	// -----------------------------------------------------------------
	// Highest priority wins; on a tie the lower source index wins.
	always_comb begin
		best_valid = 1'b0;
		best_idx   = '0;
		best_prio  = '0;
		for (int i = ifepc_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (irq_flag_regs_ff[i] && irq_enable_regs_ff[i]
				&& {1'b0, irq_priority_regs_ff[i]} > cur_level
				&& (!best_valid || irq_priority_regs_ff[i] >= best_prio)) begin
				best_valid = 1'b1;
				best_idx   = 7'(i);
				best_prio  = irq_priority_regs_ff[i];
			end
		end
	end

	// Latch vector number and new level of the presented request.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pvs_ff <= '0;
		end else begin
			pvs_ff.valid <= best_valid;
			if (best_valid) begin
				pvs_ff.vector <= best_idx + ifepc_pkg::VECTOR_BASE;
				pvs_ff.level  <= {1'b0, best_prio};
			end
		end
	end

	assign irq_req                = pvs_ff;
	assign alternate_vector_table = alt_vec_ff;

	// -----------------------------------------------------------------
	// Event status and mask
	// -----------------------------------------------------------------
	// Sticky events, cleared by writing one; a new event wins over the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_stat_ff <= '0;
		end else begin
			evt_stat_ff <= (evt_stat_ff
				& ~((wr_en && paddr == ifepc_pkg::OFS_EVT_STAT)
				? pwdata[ifepc_pkg::NUM_EVT-1:0] : '0))
				| {|trap_event, best_valid & ~pvs_ff.valid};
		end
	end

	// Event mask register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_mask_ff <= '0;
		end else if (wr_en && paddr == ifepc_pkg::OFS_EVT_MASK) begin
			evt_mask_ff <= pwdata[ifepc_pkg::NUM_EVT-1:0];
		end
	end

	assign irq_out = |(evt_stat_ff & evt_mask_ff);

	// -----------------------------------------------------------------
	// Read path
	// -----------------------------------------------------------------
	// Read multiplexer; unimplemented bits read as zero.
	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		if (paddr >= ifepc_pkg::OFS_FLAG0 && paddr < ifepc_pkg::OFS_EN0
			&& paddr[1:0] == 2'h0) begin
			rd_val[15:0] = irq_flag_regs_ff[grp_sel*16 +: 16];
		end else if (paddr >= ifepc_pkg::OFS_EN0 && paddr < ifepc_pkg::OFS_PRIO0
			&& paddr[1:0] == 2'h0) begin
			rd_val[15:0] = irq_enable_regs_ff[grp_sel*16 +: 16];
		end else if (paddr >= ifepc_pkg::OFS_PRIO0
			&& paddr < ifepc_pkg::OFS_PRIO0 + 12'(4 * ifepc_pkg::NUM_PRIO_REGS)
			&& paddr[1:0] == 2'h0) begin
			for (int k = 0; k < ifepc_pkg::PRIO_PER_REG; k++) begin
				rd_val[k*4 +: 3] = irq_priority_regs_ff[prio_sel*4 + k];
			end
		end else begin
			case (paddr)
				ifepc_pkg::OFS_GCA: begin
					rd_val[ifepc_pkg::GCA_NEST_DIS_BIT] = nesting_disable_ff;
					rd_val[NUM_TRAP-1:0] = trap_flag_ff;
				end
				ifepc_pkg::OFS_GCB: begin
					rd_val[ifepc_pkg::GCB_ALT_VEC_BIT] = alt_vec_ff;
					rd_val[NUM_EXT-1:0] = ext_edge_neg_ff;
				end
				ifepc_pkg::OFS_CPU_STAT: begin
					rd_val[ifepc_pkg::CPU_PRIO_LSB +: 3] = cpu_priority_bits_ff;
				end
				ifepc_pkg::OFS_CORE_CTL: begin
					rd_val[ifepc_pkg::CORE_TOP_BIT] = cpu_priority_top_bit_ff;
				end
				ifepc_pkg::OFS_PVS: begin
					rd_val[6:0] = pvs_ff.vector;
					rd_val[ifepc_pkg::PVS_LEVEL_LSB +: 4] = pvs_ff.level;
				end
				ifepc_pkg::OFS_EVT_STAT: begin
					rd_val[ifepc_pkg::NUM_EVT-1:0] = evt_stat_ff;
				end
				ifepc_pkg::OFS_EVT_MASK: begin
					rd_val[ifepc_pkg::NUM_EVT-1:0] = evt_mask_ff;
				end
				default: begin
					rd_hit = 1'b0;
				end
			endcase
		end
	end

	// Read data and error are captured in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= '0;
			pslverr_ff <= 1'b0;
		end else if (setup) begin
			prdata_ff  <= pwrite ? 32'h0000_0000 : rd_val;
			pslverr_ff <= ~rd_hit;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff & psel & penable;
endmodule
`default_nettype wire

// >>> ifepc_props.sv
// Checker of the interrupt controller's port behaviour.
`timescale 1ns/10ps
`default_nettype none
module ifepc_props (
	// Clock and reset.
	input wire logic                  pclk,
	input wire logic                  presetn,
	// APB slave.
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [11:0]           paddr,
	input wire logic [31:0]           pwdata,
	input wire logic                  pready,
	input wire logic [31:0]           prdata,
	input wire logic                  pslverr,
	// Processor core side.
	input wire logic                  trap_level,
	input wire logic                  irq_ack,
	input wire ifepc_pkg::ifepc_req_s irq_req,
	input wire logic                  alternate_vector_table,
	input wire logic                  irq_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	logic quiet_ff;
	// A write completes in an access cycle with pwrite high.
	assign wr = psel && penable && pwrite;
	// Remembers a cycle with no ack, no write and no trap level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_ff <= 1'b0;
		end else begin
			quiet_ff <= !irq_ack && !wr && !trap_level;
		end
	end
	// Acceptance must lift the level above the accepted one.
	property p_ack;
		logic [3:0] l;
		(irq_ack && irq_req.valid, l = irq_req.level) |-> ##2 (!irq_req.valid || irq_req.level > l);
	endproperty
	chk_ready_high: assert property (pready)
		else $error("pready is low");
	chk_err_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	chk_wr_rdata: assert property (wr |-> prdata == 32'h0)
		else $error("prdata not zero on write");
	chk_level_user: assert property (irq_req.valid |-> !irq_req.level[3])
		else $error("user level above seven");
	chk_level_above: assert property (irq_req.valid |-> irq_req.level != 4'h0)
		else $error("request at level zero");
	chk_vector_range: assert property (irq_req.valid |-> irq_req.vector inside {[7'h08:7'h47]})
		else $error("vector out of range");
	chk_ack_raise: assert property (p_ack)
		else $error("level not raised by ack");
	chk_req_holds: assert property (quiet_ff && irq_req.valid |=> irq_req.valid)
		else $error("request dropped unasked");
	chk_trap_blocks: assert property (trap_level [*3] |=> !irq_req.valid)
		else $error("request during trap level");
	chk_alt_table: assert property (wr && paddr == ifepc_pkg::OFS_GCB |=>
		alternate_vector_table == $past(pwdata[ifepc_pkg::GCB_ALT_VEC_BIT]))
		else $error("table select not written");
	// Main scenarios.
	cov_ack: cover property (irq_req.valid && irq_ack);
	cov_irq: cover property ($rose(irq_out));
	cov_err: cover property (pslverr);
endmodule
`default_nettype wire

// >>> ifepc_core_model.sv
// Behavioural processor core that accepts presented interrupt requests.
`timescale 1ns/10ps
`default_nettype none
module ifepc_core_model (
	// Clock and reset.
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// Acceptance control.
	input  wire logic                  ack_on,
	input  wire logic [3:0]            ack_dly,
	// Controller side.
	input  wire ifepc_pkg::ifepc_req_s irq_req,
	output logic                       irq_ack
);
	logic [3:0] wait_ff;
	// Accepts a presented request after ack_dly cycles, one pulse each.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_ff <= 4'h0;
			irq_ack <= 1'b0;
		end else begin
			irq_ack <= 1'b0;
			if (ack_on && irq_req.valid && !irq_ack) begin
				if (wait_ff >= ack_dly) begin
					irq_ack <= 1'b1;
					wait_ff <= 4'h0;
				end else begin
					wait_ff <= wait_ff + 4'h1;
				end
			end else begin
				wait_ff <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> interrupt_flag_enable_priority_ctrl_tb.sv
// Self-checking testbench of the interrupt controller.
`timescale 1ns/10ps
`default_nettype none
bind ifepc_ctrl ifepc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .trap_level(trap_level), .irq_ack(irq_ack),
	.irq_req(irq_req), .alternate_vector_table(alternate_vector_table), .irq_out(irq_out));
module interrupt_flag_enable_priority_ctrl_tb;
	localparam logic [11:0] a_f0 = ifepc_pkg::OFS_FLAG0;
	localparam logic [11:0] a_e0 = ifepc_pkg::OFS_EN0;
	localparam logic [11:0] a_p0 = ifepc_pkg::OFS_PRIO0;
	localparam logic [11:0] a_cpu = ifepc_pkg::OFS_CPU_STAT;
	localparam logic [11:0] a_est = ifepc_pkg::OFS_EVT_STAT;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
	logic        trap_level, irq_ack, irq_out, alternate_vector_table, ack_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	logic [63:0] src_event;
	logic [0:0]  ext_irq_pin;
	logic [4:0]  trap_event;
	logic [3:0]  ack_dly;
	int          errors, n_tests, cyc;
	ifepc_pkg::ifepc_req_s irq_req;
	ifepc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .src_event(src_event), .ext_irq_pin(ext_irq_pin),
		.trap_event(trap_event), .trap_level(trap_level), .irq_ack(irq_ack),
		.irq_req(irq_req), .alternate_vector_table(alternate_vector_table), .irq_out(irq_out));
	ifepc_core_model u_core (.pclk(pclk), .presetn(presetn), .ack_on(ack_on),
		.ack_dly(ack_dly), .irq_req(irq_req), .irq_ack(irq_ack));
	// Clock of 10 ns period.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Counts and reports a mismatch.
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("mismatch %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	// One APB transfer; read data and error land in rd_v and rd_e.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd_v = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0);
		chk(rd_v, e, m);
	endtask
	task nap(input int n);
		repeat (n) @(negedge pclk);
	endtask
	// Waits a bounded time for the request valid state, then compares it.
	task wv(input logic want);
		for (int i = 0; i < 20 && irq_req.valid !== want; i++) @(negedge pclk);
		chk({31'h0, irq_req.valid}, {31'h0, want}, "valid");
	endtask
	task rq(input logic [6:0] v, input logic [3:0] l);
		nap(2);
		wv(1'b1);
		chk({21'h0, irq_req.vector, irq_req.level}, {21'h0, v, l}, "request");
	endtask
	task ev(input logic [63:0] m);
		@(posedge pclk);
		src_event <= m;
		@(posedge pclk);
		src_event <= 64'h0;
	endtask
	task t_reset;
		rdc(a_p0, 32'h4444, "prio reset");
		rdc(a_e0, 32'h0, "enable reset");
		rdc(a_cpu, 32'h0, "cpu reset");
		wr(a_f0 + 12'h00c, 32'hffff);
		rdc(a_f0 + 12'h00c, 32'he600, "flag3 bits");
		wr(a_f0 + 12'h00c, 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		chk({31'h0, rd_e}, 32'h1, "unmapped");
		$display("test reset done");
	endtask
	task t_basic;
		wr(a_e0, 32'h1);
		ev(64'h1);
		rq(7'h08, 4'h4);
		rdc(a_f0, 32'h1, "flag sticky");
		rdc(ifepc_pkg::OFS_PVS, 32'h408, "vector status");
		wr(a_f0, 32'h0);
		wv(1'b0);
		$display("test basic done");
	endtask
	task t_select;
		wr(a_p0, 32'h0634);
		wr(a_e0, 32'h7);
		ev(64'h7);
		rq(7'h0a, 4'h6);
		wr(a_cpu, 32'hc0);
		wv(1'b0);
		wr(a_cpu, 32'h60);
		rdc(a_cpu, 32'h60, "cpu level");
		rq(7'h0a, 4'h6);
		wr(a_e0, 32'h3);
		rq(7'h08, 4'h4);
		wr(a_cpu, 32'h0);
		wr(a_f0, 32'h0);
		wv(1'b0);
		$display("test select done");
	endtask
	task t_ack;
		wr(a_p0, 32'h0654);
		wr(a_e0, 32'h2);
		ev(64'h2);
		rq(7'h09, 4'h5);
		ack_dly <= 4'h3;
		ack_on <= 1'b1;
		wv(1'b0);
		ack_on <= 1'b0;
		rdc(a_cpu, 32'ha0, "ack level");
		wr(ifepc_pkg::OFS_GCA, 32'h8000);
		wr(a_cpu, 32'h0);
		rq(7'h09, 4'h5);
		ack_dly <= 4'h0;
		ack_on <= 1'b1;
		wv(1'b0);
		ack_on <= 1'b0;
		rdc(a_cpu, 32'he0, "nest level");
		wr(ifepc_pkg::OFS_GCA, 32'h0);
		wr(a_cpu, 32'h0);
		wr(a_f0, 32'h0);
		$display("test ack done");
	endtask
	task t_event;
		wr(a_est, 32'h3);
		wr(ifepc_pkg::OFS_EVT_MASK, 32'h1);
		wr(a_e0, 32'h1);
		ev(64'h1);
		rq(7'h08, 4'h4);
		nap(2);
		chk({31'h0, irq_out}, 32'h1, "irq raised");
		wr(a_est, 32'h1);
		nap(2);
		chk({31'h0, irq_out}, 32'h0, "irq cleared");
		@(posedge pclk);
		trap_event <= 5'h04;
		@(posedge pclk);
		trap_event <= 5'h00;
		rdc(ifepc_pkg::OFS_GCA, 32'h4, "trap flag");
		rdc(a_est, 32'h2, "trap event");
		chk({31'h0, irq_out}, 32'h0, "irq masked");
		wr(ifepc_pkg::OFS_EVT_MASK, 32'h2);
		nap(2);
		chk({31'h0, irq_out}, 32'h1, "irq unmasked");
		wr(a_est, 32'h2);
		wr(ifepc_pkg::OFS_GCA, 32'h0);
		$display("test event done");
	endtask
	task t_trap;
		@(posedge pclk);
		trap_level <= 1'b1;
		wv(1'b0);
		rdc(ifepc_pkg::OFS_CORE_CTL, 32'h8, "top bit");
		wr(ifepc_pkg::OFS_CORE_CTL, 32'h0);
		rdc(ifepc_pkg::OFS_CORE_CTL, 32'h8, "top read only");
		@(posedge pclk);
		trap_level <= 1'b0;
		rq(7'h08, 4'h4);
		wr(a_f0, 32'h0);
		wr(a_e0, 32'h0);
		$display("test trap done");
	endtask
	task t_ext;
		wr(ifepc_pkg::OFS_GCB, 32'h8000);
		nap(1);
		chk({31'h0, alternate_vector_table}, 32'h1, "alt table");
		@(posedge pclk);
		ext_irq_pin <= 1'b1;
		nap(8);
		rdc(a_f0, 32'h1, "ext rising");
		wr(ifepc_pkg::OFS_GCB, 32'h1);
		wr(a_f0, 32'h0);
		@(posedge pclk);
		ext_irq_pin <= 1'b0;
		nap(8);
		rdc(a_f0, 32'h1, "ext falling");
		$display("test external done");
	endtask
	// Prints the counts and the verdict, then ends the run.
	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Cuts a hung run short.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			$display("mismatch %0t timeout", $time);
			print_verdict;
		end
	end
	// Resets the block and runs the tests.
	initial begin
		{presetn, psel, penable, pwrite, trap_level, ack_on} <= 6'h00;
		{paddr, pwdata, src_event, ext_irq_pin, trap_event, ack_dly} <= '0;
		errors = 0;
		n_tests = 0;
		cyc = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_basic;
		t_select;
		t_ack;
		t_event;
		t_trap;
		t_ext;
		print_verdict;
	end
endmodule
`default_nettype wire
